// >>> common/pwm_pkg.sv
// Package for the pulse-width-modulation output channel.
// Holds time base, duty scales, period limits, configuration defaults,
// and the enumerations used by the channel and its test bench.
// Assumes a single 125 MHz system clock.

package pwm_pkg;

    // ****************************************************************
    // Time base
    // ****************************************************************
    localparam int CLK_FREQ_MHZ  = 125;                          // System clock rate
    localparam int TICK_TIME_US  = 1;                            // One time-base step
    localparam int TICK_CYCLES   = TICK_TIME_US * CLK_FREQ_MHZ;  // Clocks per step
    localparam int TICK_CNT_W    = $clog2(TICK_CYCLES);          // Divider width

    // ****************************************************************
    // Duty scales
    // ****************************************************************
    localparam logic [14:0] SCALE_HUNDREDTHS   = 15'h0064;  // 100
    localparam logic [14:0] SCALE_THOUSANDTHS  = 15'h03e8;  // 1 000
    localparam logic [14:0] SCALE_TEN_THOUSAND = 15'h2710;  // 10 000
    localparam logic [14:0] SCALE_ANALOG       = 15'h6c00;  // 27 648

    // Duty scale selector
    typedef enum logic [1:0] {
        PWM_FMT_HUNDREDTHS,
        PWM_FMT_THOUSANDTHS,
        PWM_FMT_TEN_THOUSANDTHS,
        PWM_FMT_ANALOG
    } pwm_format_t;

    // Output driver class, selects the lower period limit
    typedef enum logic [1:0] {
        PWM_DRV_STANDARD,
        PWM_DRV_FAST_OFF,
        PWM_DRV_FAST_ON
    } pwm_drive_t;

    // Channel sequencer states
    typedef enum logic {
        PWM_ST_IDLE,
        PWM_ST_RUN
    } pwm_state_t;

    // ****************************************************************
    // Period and minimum-pulse limits, microseconds
    // ****************************************************************
    localparam logic [31:0] PERIOD_MIN_STD_US     = 32'h0000_2710;  // 10 000
    localparam logic [31:0] PERIOD_MIN_FAST_OFF_US = 32'h0000_0064; // 100
    localparam logic [31:0] PERIOD_MIN_FAST_ON_US = 32'h0000_000a;  // 10
    localparam logic [31:0] PERIOD_MAX_US         = 32'h0098_9680;  // 10 000 000
    localparam logic [31:0] MIN_PULSE_MAX_US      = 32'h0098_9680;  // 10 000 000

    // ****************************************************************
    // Control field codes
    // ****************************************************************
    localparam logic [3:0] LOAD_SEL_PERIOD   = 4'h1;   // Load field carries the period
    localparam logic [7:0] CFG_RECORD_NUMBER = 8'h80;  // Parameter record 128

    // ****************************************************************
    // Configuration reset values
    // ****************************************************************
    localparam logic [31:0] CFG_PERIOD_RST     = 32'h0000_2710;
    localparam logic [31:0] CFG_MIN_PULSE_RST  = 32'h0000_0000;
    localparam pwm_format_t CFG_FORMAT_RST     = PWM_FMT_HUNDREDTHS;
    localparam pwm_drive_t  CFG_DRIVE_RST      = PWM_DRV_STANDARD;
    localparam logic        CFG_STOP_CONT_RST  = 1'h0;
    localparam logic        CFG_STOP_LEVEL_RST = 1'h0;

endpackage : pwm_pkg

// >>> src/pwm_pulse_calc.sv
// Pulse duration calculator: duty / scale * period, in microseconds.
// Assumes operands stay steady for about fifty clocks; the result is
// refreshed continuously by a bit-serial divider.

`timescale 1ns/10ps
`default_nettype none

module pwm_pulse_calc
    import pwm_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Operands
    input  wire logic [15:0] duty,
    input  wire logic [14:0] scale,
    input  wire logic [31:0] period_us,
    // Result
    output logic      [31:0] pulse_us
);

    localparam logic [5:0] DIV_STEPS = 6'h30;  // One step per dividend bit

    logic [47:0] dividend;       // Product being shifted out
    logic [14:0] remainder;      // Partial remainder
    logic [31:0] quotient;       // Quotient being built
    logic [5:0]  step;           // Steps left, zero means reload
    logic [47:0] next_dividend;
    logic [14:0] next_remainder;
    logic [31:0] next_quotient;
    logic [5:0]  next_step;
    logic [31:0] next_pulse_us;
    logic [15:0] duty_lim;       // Duty held to full scale
    logic [15:0] trial;          // Remainder with the next bit shifted in
    logic        qbit;           // Next quotient bit

    // ****************************************************************
    // Serial restoring divider
    // ****************************************************************
    // A serial divider costs one subtractor; fifty clocks is far below
    // one microsecond, so the result is never stale by a whole step.
    always_comb begin
        duty_lim       = (duty > {1'b0, scale}) ? {1'b0, scale} : duty;
        trial          = {remainder, dividend[47]};
        qbit           = (trial >= {1'b0, scale});
        next_dividend  = dividend;
        next_remainder = remainder;
        next_quotient  = quotient;
        next_step      = step;
        next_pulse_us  = pulse_us;
        if (step == 6'h00) begin
            // Take a fresh product of the operands
            next_dividend  = 48'(duty_lim * period_us);
            next_remainder = 15'h0000;
            next_quotient  = 32'h0000_0000;
            next_step      = DIV_STEPS;
        end else begin
            // Shift one bit, subtract when it fits
            next_remainder = qbit ? 15'(trial - {1'b0, scale}) : trial[14:0];
            next_dividend  = {dividend[46:0], 1'b0};
            next_quotient  = {quotient[30:0], qbit};
            next_step      = step - 6'h01;
            if (step == 6'h01) begin
                next_pulse_us = {quotient[30:0], qbit};
            end
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dividend  <= 48'h0000_0000_0000;
            remainder <= 15'h0000;
            quotient  <= 32'h0000_0000;
            step      <= 6'h00;
            pulse_us  <= 32'h0000_0000;
        end else begin
            dividend  <= next_dividend;
            remainder <= next_remainder;
            quotient  <= next_quotient;
            step      <= next_step;
            pulse_us  <= next_pulse_us;
        end
    end

endmodule : pwm_pulse_calc

`default_nettype wire

// >>> src/pwm_channel.sv
// One pulse-width-modulation output channel.
// Assumes synchronous control inputs and a 125 MHz clock; all control,
// configuration and status bits are plain ports.

`timescale 1ns/10ps
`default_nettype none

module pwm_channel
    import pwm_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Run control and status
    input  wire logic        run_request,
    output logic             run_request_seen,
    output logic             sequence_active,
    // Duty value
    input  wire logic [15:0] duty_value,
    // Period load fields
    input  wire logic [31:0] load_value,
    input  wire logic [3:0]  load_target_select,
    input  wire logic        load_update_mode,
    output logic             load_error,
    // Output ownership
    input  wire logic        generator_owns_output,
    input  wire logic        manual_output_level,
    // Controller stop
    input  wire logic        controller_stop,
    // Parameter record write
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_record,
    input  wire logic [31:0] cfg_period_us,
    input  wire logic [31:0] cfg_min_pulse_us,
    input  wire pwm_format_t cfg_format,
    input  wire pwm_drive_t  cfg_drive,
    input  wire logic        cfg_stop_continue,
    input  wire logic        cfg_stop_level,
    output logic             record_error,
    // Pulse output
    output logic             pulse_output_pin
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [TICK_CNT_W-1:0] tick_cnt;          // Microsecond divider
    logic [TICK_CNT_W-1:0] next_tick_cnt;
    logic                  tick;              // One-cycle microsecond enable
    logic                  next_tick;

    logic [31:0] par_period;                  // Configured period
    logic [31:0] par_min_pulse;               // Minimum pulse and gap
    pwm_format_t par_format;                  // Duty scale
    pwm_drive_t  par_drive;                   // Driver class
    logic        par_stop_continue;           // Keep running on stop
    logic        par_stop_level;              // Substitute level on stop
    logic [31:0] next_par_period;
    logic [31:0] next_par_min_pulse;
    pwm_format_t next_par_format;
    pwm_drive_t  next_par_drive;
    logic        next_par_stop_continue;
    logic        next_par_stop_level;
    logic        next_record_error;
    logic        record_ok;                   // Record contents acceptable
    logic        record_apply;                // Record taken this cycle

    pwm_state_t  state;                       // Sequencer state
    pwm_state_t  next_state;
    logic        run_prev;                    // Run request last cycle
    logic        sel_prev;                    // Period selected last cycle
    logic [31:0] cycle_us;                    // Position within the period
    logic [31:0] period_cur;                  // Period in force
    logic [31:0] pulse_cur;                   // Pulse in force
    logic [31:0] held_period;                 // Period from record or one-time load
    logic [31:0] next_cycle_us;
    logic [31:0] next_period_cur;
    logic [31:0] next_pulse_cur;
    logic [31:0] next_held_period;
    logic        next_load_error;
    logic        next_active;
    logic        next_pin;

    logic        run_rise;                    // Run request edges
    logic        run_fall;
    logic        sel_period;                  // Load field targets period
    logic        load_ok;                     // Load value in range
    logic        perm_load;                   // Permanent load in effect
    logic        once_load;                   // One-time load request
    logic [31:0] eff_period;                  // Period for the next start
    logic [14:0] scale;                       // Divisor for the duty value
    logic [31:0] calc_pulse;                  // Raw pulse duration
    logic [31:0] clamp_pulse;                 // Pulse after limits
    logic        period_end;                  // Last microsecond of the period
    logic        gen_level;                   // Generator waveform level

    // Lower period limit for a driver class
    function automatic logic [31:0] period_floor(input pwm_drive_t drv);
        logic [31:0] floor_us;
        floor_us = PERIOD_MIN_STD_US;
        unique case (drv)
            PWM_DRV_STANDARD: floor_us = PERIOD_MIN_STD_US;
            PWM_DRV_FAST_OFF: floor_us = PERIOD_MIN_FAST_OFF_US;
            PWM_DRV_FAST_ON:  floor_us = PERIOD_MIN_FAST_ON_US;
            default:          floor_us = PERIOD_MIN_STD_US;  // Unused code
        endcase
        return floor_us;
    endfunction : period_floor

    // ****************************************************************
    // Microsecond time base
    // ****************************************************************
    always_comb begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 1'b1;
        if (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // ****************************************************************
    // Parameter record
    // ****************************************************************
    // A rejected record leaves every setting as it was, so a bad write
    // can never leave the channel half reconfigured.
    always_comb begin
        record_ok = (cfg_period_us >= period_floor(cfg_drive))
                  && (cfg_period_us <= PERIOD_MAX_US)
                  && (cfg_min_pulse_us <= MIN_PULSE_MAX_US);
        record_apply           = cfg_write && (cfg_record == CFG_RECORD_NUMBER)
                               && record_ok;
        next_par_period        = par_period;
        next_par_min_pulse     = par_min_pulse;
        next_par_format        = par_format;
        next_par_drive         = par_drive;
        next_par_stop_continue = par_stop_continue;
        next_par_stop_level    = par_stop_level;
        next_record_error      = record_error;
        if (cfg_write) begin
            next_record_error = !record_apply;
        end
        if (record_apply) begin
            next_par_period        = cfg_period_us;
            next_par_min_pulse     = cfg_min_pulse_us;
            next_par_format        = cfg_format;
            next_par_drive         = cfg_drive;
            next_par_stop_continue = cfg_stop_continue;
            next_par_stop_level    = cfg_stop_level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_period        <= CFG_PERIOD_RST;
            par_min_pulse     <= CFG_MIN_PULSE_RST;
            par_format        <= CFG_FORMAT_RST;
            par_drive         <= CFG_DRIVE_RST;
            par_stop_continue <= CFG_STOP_CONT_RST;
            par_stop_level    <= CFG_STOP_LEVEL_RST;
            record_error      <= 1'b0;
        end else begin
            par_period        <= next_par_period;
            par_min_pulse     <= next_par_min_pulse;
            par_format        <= next_par_format;
            par_drive         <= next_par_drive;
            par_stop_continue <= next_par_stop_continue;
            par_stop_level    <= next_par_stop_level;
            record_error      <= next_record_error;
        end
    end

    // ****************************************************************
    // Period source and pulse duration
    // ****************************************************************
    always_comb begin
        sel_period = (load_target_select == LOAD_SEL_PERIOD);
        load_ok    = (load_value >= period_floor(par_drive))
                   && (load_value <= PERIOD_MAX_US);
        perm_load  = load_update_mode && sel_period;
        once_load  = !load_update_mode && sel_period && !sel_prev;
        eff_period = (perm_load && load_ok) ? load_value : held_period;
        unique case (par_format)
            PWM_FMT_HUNDREDTHS:      scale = SCALE_HUNDREDTHS;
            PWM_FMT_THOUSANDTHS:     scale = SCALE_THOUSANDTHS;
            PWM_FMT_TEN_THOUSANDTHS: scale = SCALE_TEN_THOUSAND;
            PWM_FMT_ANALOG:          scale = SCALE_ANALOG;
        endcase
        // Limits: too short is dropped, too close to full becomes full
        if (calc_pulse < par_min_pulse) begin
            clamp_pulse = 32'h0000_0000;
        end else if (33'(calc_pulse) + 33'(par_min_pulse) > 33'(eff_period)) begin
            clamp_pulse = eff_period;
        end else begin
            clamp_pulse = calc_pulse;
        end
    end

    // Duty times period over scale, refreshed continuously
    pwm_pulse_calc u_calc (
        .clk       (clk),
        .rst_n     (rst_n),
        .duty      (duty_value),
        .scale     (scale),
        .period_us (eff_period),
        .pulse_us  (calc_pulse)
    );

    // ****************************************************************
    // Sequencer and output
    // ****************************************************************
    // New duty and period are only sampled where a period starts, which
    // is where the output rises, so they never cut a running pulse; run_fall does.
    always_comb begin
        run_rise         = run_request && !run_prev;
        run_fall         = !run_request && run_prev;
        period_end       = tick && (cycle_us + 32'h0000_0001 >= period_cur);
        next_state       = state;
        next_cycle_us    = cycle_us;
        next_period_cur  = period_cur;
        next_pulse_cur   = pulse_cur;
        next_active      = sequence_active;
        next_held_period = held_period;
        next_load_error  = load_error;
        if (record_apply) begin
            next_held_period = next_par_period;
        end else if (once_load && load_ok) begin
            next_held_period = load_value;
        end
        if (once_load || perm_load) begin
            next_load_error = !load_ok;
        end
        unique case (state)
            PWM_ST_IDLE: begin
                if (run_rise) begin
                    next_state      = PWM_ST_RUN;
                    next_active     = 1'b1;
                    next_cycle_us   = 32'h0000_0000;
                    next_period_cur = eff_period;
                    next_pulse_cur  = clamp_pulse;
                end
            end
            PWM_ST_RUN: begin
                if (run_fall) begin
                    next_state    = PWM_ST_IDLE;
                    next_active   = 1'b0;
                    next_cycle_us = 32'h0000_0000;
                end else if (period_end) begin
                    next_cycle_us   = 32'h0000_0000;
                    next_period_cur = eff_period;
                    next_pulse_cur  = clamp_pulse;
                end else if (tick) begin
                    next_cycle_us = cycle_us + 32'h0000_0001;
                end
            end
        endcase
        // High from period start for the pulse time, low after
        gen_level = (next_state == PWM_ST_RUN)
                  && (next_cycle_us < next_pulse_cur);
        if (controller_stop && !par_stop_continue) begin
            next_pin = par_stop_level;
        end else if (generator_owns_output) begin
            next_pin = gen_level;
        end else begin
            next_pin = manual_output_level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state            <= PWM_ST_IDLE;
            run_prev         <= 1'b0;
            sel_prev         <= 1'b0;
            cycle_us         <= 32'h0000_0000;
            period_cur       <= CFG_PERIOD_RST;
            pulse_cur        <= 32'h0000_0000;
            held_period      <= CFG_PERIOD_RST;
            load_error       <= 1'b0;
            sequence_active  <= 1'b0;
            run_request_seen <= 1'b0;
            pulse_output_pin <= 1'b0;
        end else begin
            state            <= next_state;
            run_prev         <= run_request;
            sel_prev         <= sel_period;
            cycle_us         <= next_cycle_us;
            period_cur       <= next_period_cur;
            pulse_cur        <= next_pulse_cur;
            held_period      <= next_held_period;
            load_error       <= next_load_error;
            sequence_active  <= next_active;
            run_request_seen <= run_request;
            pulse_output_pin <= next_pin;
        end
    end

endmodule : pwm_channel

`default_nettype wire

// >>> bench/pwm_channel_monitor.sv
// Checker for the output channel, bound to pwm_channel ports.
// Assumes the bench changes configuration ports only around a record write.
`timescale 1ns/10ps
`default_nettype none
module pwm_channel_monitor (
    input wire logic       clk, rst_n, run_request, run_request_seen, sequence_active,
    input wire logic       generator_owns_output, manual_output_level, controller_stop,
    input wire logic       cfg_stop_continue, cfg_stop_level, cfg_write, record_error,
    input wire logic [7:0] cfg_record,
    input wire logic       pulse_output_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SEEN: assert property (##1 run_request_seen == $past(run_request))
        else $error("seen status lags wrongly");
    AST_START: assert property ($rose(run_request) |=> sequence_active)
        else $error("no start");
    AST_HOLD: assert property (sequence_active && run_request |=> sequence_active)
        else $error("active dropped");
    AST_ABORT: assert property ($fell(run_request) && generator_owns_output && !controller_stop
        |=> !sequence_active && !pulse_output_pin) else $error("abort late");
    AST_MANUAL: assert property (!generator_owns_output && !controller_stop
        |=> pulse_output_pin == $past(manual_output_level)) else $error("manual level");
    AST_IDLE: assert property (!sequence_active && $past(generator_owns_output)
        && !$past(controller_stop) |-> !pulse_output_pin) else $error("idle pin high");
    AST_STOP: assert property (controller_stop && !cfg_stop_continue
        |=> pulse_output_pin == cfg_stop_level) else $error("stop level");
    AST_REC: assert property (cfg_write && cfg_record != 8'h80 |=> record_error)
        else $error("bad record taken");
endmodule : pwm_channel_monitor
bind pwm_channel pwm_channel_monitor u_pwm_channel_monitor (.*);
`default_nettype wire

// >>> bench/pwm_program_model.sv
// User program side: turns a bench command into the run request.
// Assumes the bench gives commands at falling edges.
`timescale 1ns/10ps
`default_nettype none
module pwm_program_model (
    input  wire logic clk, rst_n, go,
    output logic      run_request
);
    // Each start after a cancel is a fresh rise, never a held level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) run_request <= 1'h0;
        else run_request <= go;
    end
endmodule : pwm_program_model
`default_nettype wire

// >>> bench/tb_pwm_channel.sv
// Self-checking bench for pwm_channel; a monitor pops expected widths.
// Assumes 125 clocks per microsecond and fast-on drive.
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_channel;
    import pwm_pkg::*;
    logic clk = 0, rst_n = 0, go = 0, run_request, seen, act, lerr, rerr, pin, ok;
    logic [15:0] duty = 16'h0;
    logic [31:0] lval = 32'h0, prd = 32'h14, mp = 32'h0;
    logic [3:0] lsel = 4'h0;
    logic [7:0] rec = 8'h80;
    logic lmode = 0, own = 1, man = 0, stp = 0, cw = 0, scont = 0, slev = 0;
    pwm_format_t fmt = PWM_FMT_HUNDREDTHS;
    pwm_drive_t drv = PWM_DRV_FAST_ON;     // Driver class, sets the period floor
    logic [14:0] sc [4] = '{SCALE_HUNDREDTHS, SCALE_THOUSANDTHS, SCALE_TEN_THOUSAND, SCALE_ANALOG};
    int n_fail = 0, n_checks = 0, seed = 53839, hi = 0, e, d, q[$];
    always #4 clk = ~clk;
    pwm_program_model u_pwm_program_model (.clk(clk), .rst_n(rst_n), .go(go),
        .run_request(run_request));
    pwm_channel u_pwm_channel (.clk(clk), .rst_n(rst_n), .run_request(run_request),
        .run_request_seen(seen), .sequence_active(act), .duty_value(duty),
        .load_value(lval), .load_target_select(lsel), .load_update_mode(lmode),
        .load_error(lerr), .generator_owns_output(own), .manual_output_level(man),
        .controller_stop(stp), .cfg_write(cw), .cfg_record(rec), .cfg_period_us(prd),
        .cfg_min_pulse_us(mp), .cfg_format(fmt), .cfg_drive(drv),
        .cfg_stop_continue(scont), .cfg_stop_level(slev), .record_error(rerr),
        .pulse_output_pin(pin));
    // Width of each high pulse against the oldest note; first us may be short
    always @(posedge clk) begin
        if (pin === 1'b1) hi <= hi + 1;
        else begin
            if (hi > 0 && q.size() > 0) begin
                e = q.pop_front();
                n_checks++;
                if (hi > e + 2 || hi + 126 < e) begin
                    n_fail++;
                    $display("BAD %0t width %0d not %0d", $time, hi, e);
                end
            end
            hi <= 0;
        end
    end
    task automatic close_out();
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic chk(input logic c, input string m);
        n_checks++;
        if (c !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic wait_pin(input logic v);
        for (int i = 0; i < 4000 && pin !== v; i++) @(negedge clk);
        if (pin !== v) begin
            n_fail++;
            $display("BAD %0t pin stuck", $time);
            close_out();
        end
    endtask : wait_pin
    task automatic stay(input logic v, input string m);
        ok = 1;
        repeat (3000) begin
            @(negedge clk);
            if (pin !== v) ok = 0;
        end
        chk(ok, m);
        chk(seen === 1'b1 && act === 1'b1, "run status");
        go = 0;
        repeat (4) @(negedge clk);
    endtask : stay
    task automatic cfg(input logic [7:0] r);
        rec = r;
        cw = 1;
        @(negedge clk);
        cw = 0;
        @(negedge clk);
    endtask : cfg
    // Duty must settle in the pulse calculator before the run rise takes it
    task automatic start(input logic [15:0] dv);
        duty = dv;
        repeat (150) @(negedge clk);
        go = 1;
    endtask : start
    // Second duty is written mid-pulse and must not touch this pulse
    task automatic pulse(input logic [15:0] d0, d1, input int w);
        duty = d0;
        repeat (150) @(negedge clk);
        q.push_back(w);
        go = 1;
        wait_pin(1);
        duty = d1;
        wait_pin(0);
        go = 0;
        repeat (4) @(negedge clk);
    endtask : pulse
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        chk(pin === 0 && act === 0 && rerr === 0, "reset");
        cfg(8'h7f); chk(rerr === 1'b1, "record kept");
        for (int f = 0; f < 4; f++) begin
            fmt = pwm_format_t'(f);
            cfg(8'h80);
            pulse({1'b0, sc[f] >> 2}, {1'b0, sc[f]}, 625);
        end
        drv = PWM_DRV_STANDARD; cfg(8'h80); chk(rerr === 1'b1, "drive floor");
        drv = PWM_DRV_FAST_ON;
        fmt = PWM_FMT_HUNDREDTHS; cfg(8'h80); chk(rerr === 1'b0, "record");
        // Below 5 the pulse floors to zero and no rising edge would come
        repeat (2) begin
            d = 5 + ($unsigned($random(seed)) % 95);
            pulse(d[15:0], 16'h0, (d * 20 / 100) * 125);
        end
        start(16'h0); stay(0, "zero duty");
        start(16'h64); wait_pin(1); stay(1, "full duty");
        lval = 32'h28; lsel = 4'h1; pulse(16'h32, 16'h32, 2500);
        lsel = 4'h0; lmode = 1; lval = 32'h10;
        @(negedge clk); lsel = 4'h1; pulse(16'h32, 16'h32, 1000);
        lsel = 4'h0; lmode = 0; lval = 32'h5;
        @(negedge clk); lsel = 4'h1; repeat (3) @(negedge clk);
        chk(lerr === 1'b1, "short period"); lsel = 4'h0;
        mp = 32'h3; cfg(8'h80);
        start(16'ha); stay(0, "short pulse");
        start(16'h5a); wait_pin(1); stay(1, "long pulse");
        own = 0; man = 1; repeat (2) @(negedge clk); chk(pin === 1'b1, "manual");
        own = 1; slev = 1; cfg(8'h80); stp = 1;
        repeat (2) @(negedge clk); chk(pin === 1'b1, "stop"); stp = 0;
        // Continue keeps the idle generator level, not the substitute level
        scont = 1; cfg(8'h80); stp = 1;
        repeat (2) @(negedge clk); chk(pin === 1'b0, "stop continue"); stp = 0;
        close_out();
    end
endmodule : tb_pwm_channel
`default_nettype wire
